// ### sabi_pkg.sv
package sabi_pkg;

	// clock of the control logic
	localparam int CLK_PERIOD_NS = 100;

	// approximation register
	localparam int RES_BITS = 8;
	localparam logic [7:0] SAR_MIDSCALE = 8'h80;
	localparam logic [7:0] SAR_RESET_VAL = 8'h00;
	localparam logic [2:0] MSB_INDEX = 3'h7;

	// conversion timing on the internal oscillator
	localparam int CONV_TIME_NS = 15000;
	localparam int BIT_CYC = CONV_TIME_NS / (RES_BITS * CLK_PERIOD_NS);

	// extra start delay when a read restarts the converter
	localparam int ROM_EXTRA_NS = 2000;
	localparam int ROM_EXTRA_CYC = ROM_EXTRA_NS / CLK_PERIOD_NS;

	// width of the shared timing counter
	localparam int CNT_W = 8;

	// control states
	typedef enum logic [2:0] {
		SABI_ST_DONE,
		SABI_ST_READY,
		SABI_ST_ROMWAIT,
		SABI_ST_CONV,
		SABI_ST_CLEAR
	} sabi_state_t;

endpackage

// ### sabi_ctrl.sv
`timescale 1ns/1ns

module sabi_ctrl #(
	parameter int BIT_CYCLES = sabi_pkg::BIT_CYC,
	parameter int ROM_CYCLES = sabi_pkg::ROM_EXTRA_CYC
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic select_n_i,
	input wire logic read_n_i,
	input wire logic cmp_below_i,
	input wire logic ext_clk_sel_i,
	input wire logic ext_clk_i,
	output logic busy_n_o,
	output logic conv_clk_run_o,
	output logic [7:0] trial_code_o,
	output logic [7:0] result_bus_o,
	output logic result_bus_oe_n_o
);

	// pin synchronisers, first stage read only by second
	logic sel_s1_q, sel_s2_q, sel_prev_q;
	logic rd_s1_q, rd_s2_q, rd_prev_q;
	logic cmp_s1_q, cmp_s2_q;
	logic xsel_s1_q, xsel_s2_q;
	logic xclk_s1_q, xclk_s2_q, xclk_prev_q;

	// state, approximation register, trial index, shared counter, bus enable
	sabi_pkg::sabi_state_t state_q;
	logic [7:0] sar_q;
	logic [2:0] bit_q;
	logic [sabi_pkg::CNT_W-1:0] cnt_q;
	logic oe_n_q;

	// edges, period ends and decoded conditions
	logic rd_rise;
	logic xclk_rise;
	logic bit_tick;
	logic clear_end;
	logic rom_end;
	logic read_active;

	// decoded state flags
	logic in_conv;
	logic in_busy;
	logic in_done;
	logic in_clear;
	logic in_romwait;

	// true while the approximation steps run
	function automatic logic sabi_is_conv(input sabi_pkg::sabi_state_t st);
		return st == sabi_pkg::SABI_ST_CONV;
	endfunction

	// true while the host must be held off by busy;
	// the restart delay counts as busy as well
	function automatic logic sabi_is_busy(input sabi_pkg::sabi_state_t st);
		return (st == sabi_pkg::SABI_ST_CONV) || (st == sabi_pkg::SABI_ST_ROMWAIT);
	endfunction

	// true while a finished result waits to be read
	function automatic logic sabi_is_done(input sabi_pkg::sabi_state_t st);
		return st == sabi_pkg::SABI_ST_DONE;
	endfunction

	// true during the one-period internal reset
	function automatic logic sabi_is_clear(input sabi_pkg::sabi_state_t st);
		return st == sabi_pkg::SABI_ST_CLEAR;
	endfunction

	// true during the restart delay of the read-restart style
	function automatic logic sabi_is_romwait(input sabi_pkg::sabi_state_t st);
		return st == sabi_pkg::SABI_ST_ROMWAIT;
	endfunction

	// one successive-approximation step on the current trial bit:
	// keeps or clears the bit under trial and sets the next lower one;
	// at bit zero nothing lower is set, the result is then complete
	function automatic logic [7:0] sabi_next_sar(input logic [7:0] sar, input logic [2:0] idx,
		input logic keep);
		logic [7:0] v;
		v = sar;
		v[idx] = keep;
		if (idx != 3'h0) begin
			v[idx - 3'h1] = 1'b1;
		end
		return v;
	endfunction

	// pins are asynchronous to clock_i, so each passes two flip-flops
	// before any logic reads it; only the second stage is read by logic,
	// and a third stage keeps the previous value for edge detection.
	// the comparator and clock-select inputs come from outside this clock too.
	// reset values match the idle pin levels, so no false edge follows reset

	// select pin: two-stage synchroniser plus edge history
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			sel_prev_q <= 1'b1;
		end else begin
			sel_s1_q <= select_n_i;
			sel_s2_q <= sel_s1_q;
			sel_prev_q <= sel_s2_q;
		end
	end

	// read strobe pin: two-stage synchroniser plus edge history
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rd_s1_q <= 1'b1;
			rd_s2_q <= 1'b1;
			rd_prev_q <= 1'b1;
		end else begin
			rd_s1_q <= read_n_i;
			rd_s2_q <= rd_s1_q;
			rd_prev_q <= rd_s2_q;
		end
	end

	// comparator decision: two-stage synchroniser
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end else begin
			cmp_s1_q <= cmp_below_i;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	// external clock select: two-stage synchroniser
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			xsel_s1_q <= 1'b0;
			xsel_s2_q <= 1'b0;
		end else begin
			xsel_s1_q <= ext_clk_sel_i;
			xsel_s2_q <= xsel_s1_q;
		end
	end

	// external clock pin: idles high through its pull-up while busy is high
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			xclk_s1_q <= 1'b1;
			xclk_s2_q <= 1'b1;
			xclk_prev_q <= 1'b1;
		end else begin
			xclk_s1_q <= ext_clk_i;
			xclk_s2_q <= xclk_s1_q;
			xclk_prev_q <= xclk_s2_q;
		end
	end

	// decoded state flags shared by the processes below
	assign in_conv = sabi_is_conv(state_q);
	assign in_busy = sabi_is_busy(state_q);
	assign in_done = sabi_is_done(state_q);
	assign in_clear = sabi_is_clear(state_q);
	assign in_romwait = sabi_is_romwait(state_q);

	// read rising counts only if select was already low a cycle earlier;
	// select and read rising together in one cycle still count, since the
	// edge history of select lags by one stage
	assign rd_rise = rd_s2_q && !rd_prev_q && !sel_prev_q;
	// external clock edges, seen after synchronisation
	assign xclk_rise = xclk_s2_q && !xclk_prev_q;

	// ends of the internal oscillator period and of the restart delay
	assign clear_end = (cnt_q == sabi_pkg::CNT_W'(BIT_CYCLES - 1));
	assign rom_end = (cnt_q == sabi_pkg::CNT_W'(ROM_CYCLES - 1));

	// external clock only counts while converting, like a busy-gated buffer;
	// the comparator is sampled two edges late, so a bit period needs
	// at least three edges
	assign bit_tick = in_conv && (xsel_s2_q ? xclk_rise : clear_end);
	// a read after completion opens the result bus
	assign read_active = in_done && !sel_s2_q && !rd_s2_q;

	// control sequence; style follows from the pin sequence alone
	// DONE waits for a read, CLEAR is the one-period internal reset,
	// READY waits for select, ROMWAIT is the restart delay of the
	// read-restart style, CONV tries one bit per oscillator period.
	// latency: a pin change is seen two edges later, busy falls one
	// edge after that; the bus opens one edge after a seen read.
	// hazard: select left low after the internal reset restarts the
	// converter, so a static-RAM host must release it with the read.
	// style is never stored: the same states serve all three styles.
	// pins are ignored in CONV and ROMWAIT; select alone in DONE too.
	// reset enters DONE so that the first read clears power-up state
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_q <= sabi_pkg::SABI_ST_DONE; // dummy read clears power-up state
		end else begin
			case (state_q)
				sabi_pkg::SABI_ST_READY: begin
					// wait for a start; a write or a combined read both start here
					if (!sel_s2_q) begin
						state_q <= sabi_pkg::SABI_ST_CONV;
					end
				end
				sabi_pkg::SABI_ST_ROMWAIT: begin
					// restart delay, busy already low
					if (rom_end) begin
						state_q <= sabi_pkg::SABI_ST_CONV;
					end
				end
				sabi_pkg::SABI_ST_CONV: begin
					// pins are ignored here
					if (bit_tick && bit_q == 3'h0) begin
						state_q <= sabi_pkg::SABI_ST_DONE;
					end
				end
				sabi_pkg::SABI_ST_DONE: begin
					// only a read ends this state, a write is ignored
					if (rd_rise) begin
						state_q <= sabi_pkg::SABI_ST_CLEAR;
					end
				end
				sabi_pkg::SABI_ST_CLEAR: begin
					// one oscillator period, then midscale is loaded
					if (clear_end) begin
						if (!sel_s2_q) begin
							state_q <= sabi_pkg::SABI_ST_ROMWAIT;
						end else begin
							state_q <= sabi_pkg::SABI_ST_READY;
						end
					end
				end
				default: begin
					// unused codes fall back to waiting for a read
					state_q <= sabi_pkg::SABI_ST_DONE;
				end
			endcase
		end
	end

	// oscillator period counter, restarted at each state change;
	// one counter serves the bit period, the internal reset and the
	// restart delay, since only one of them runs at a time
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cnt_q <= '0;
		end else if (in_conv) begin
			if (clear_end || bit_tick) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + sabi_pkg::CNT_W'(1);
			end
		end else if (in_clear) begin
			if (clear_end) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + sabi_pkg::CNT_W'(1);
			end
		end else if (in_romwait) begin
			if (rom_end) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + sabi_pkg::CNT_W'(1);
			end
		end else begin
			cnt_q <= '0;
		end
	end

	// approximation register: midscale after the internal reset,
	// then one decision per bit tick
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sar_q <= sabi_pkg::SAR_RESET_VAL;
		end else if (in_clear && clear_end) begin
			sar_q <= sabi_pkg::SAR_MIDSCALE;
		end else if (bit_tick) begin
			sar_q <= sabi_next_sar(sar_q, bit_q, cmp_s2_q);
		end
	end

	// trial bit index, most significant first
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			bit_q <= sabi_pkg::MSB_INDEX;
		end else if (in_clear && clear_end) begin
			bit_q <= sabi_pkg::MSB_INDEX;
		end else if (bit_tick) begin
			bit_q <= bit_q - 3'h1;
		end
	end

	// bus enable, registered from a read after completion;
	// it stays high in every other state, so a read while busy floats the bus
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= !read_active;
		end
	end

	// busy low through the restart delay and the conversion
	assign busy_n_o = !in_busy;
	// conversion clock runs while converting and for the one-period reset
	assign conv_clk_run_o = in_conv || in_clear;
	// the weighting converter sees every trial code as it is formed
	assign trial_code_o = sar_q;
	// bus data always shows the register; the enable decides if it is driven
	assign result_bus_o = sar_q;
	assign result_bus_oe_n_o = oe_n_q;

endmodule

// ### sabi_ctrl_assertions.sv
`timescale 1ns/1ns
module sabi_ctrl_checker (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic select_n_i,
	input wire logic read_n_i,
	input wire logic busy_n_o,
	input wire logic conv_clk_run_o,
	input wire logic [7:0] trial_code_o,
	input wire logic result_bus_oe_n_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// the bus is driven only for a read after completion
	drive_after_done_a: assert property (!result_bus_oe_n_o |-> busy_n_o && !$past(read_n_i, 3))
		else $error("result bus driven outside a read");
	oe_needs_select_a: assert property ($fell(result_bus_oe_n_o) |-> !$past(select_n_i, 3))
		else $error("result bus driven without select");
	busy_min_span_a: assert property ($fell(busy_n_o) |-> !busy_n_o [*8])
		else $error("busy too short");
	busy_bounded_a: assert property ($fell(busy_n_o) |-> ##[1:200] $rose(busy_n_o))
		else $error("conversion never completed");
	start_midscale_a: assert property ($fell(busy_n_o) |-> trial_code_o == 8'h80)
		else $error("conversion not started from midscale");
	clock_stops_a: assert property ($rose(busy_n_o) |-> !conv_clk_run_o)
		else $error("conversion clock still running");
	code_frozen_a: assert property (!conv_clk_run_o && !$past(conv_clk_run_o) |-> $stable(trial_code_o))
		else $error("code changed with clock stopped");
	result_held_a: assert property ($rose(busy_n_o) |-> busy_n_o [*4])
		else $error("new conversion before result read");
	cover property ($fell(busy_n_o));
	cover property ($fell(result_bus_oe_n_o));
	cover property (!busy_n_o && !read_n_i);
endmodule
bind sabi_ctrl sabi_ctrl_checker chk (.clock_i(clock_i), .reset_i(reset_i), .select_n_i(select_n_i),
	.read_n_i(read_n_i), .busy_n_o(busy_n_o), .conv_clk_run_o(conv_clk_run_o), .trial_code_o(trial_code_o),
	.result_bus_oe_n_o(result_bus_oe_n_o));

// ### sabi_far.sv
`timescale 1ns/1ns
module sabi_far (
	input wire logic [7:0] ain_i,
	input wire logic [7:0] trial_code_i,
	input wire logic busy_n_i,
	input wire logic osc_i,
	output logic cmp_below_o,
	output logic ext_clk_o
);
	// comparator: weighted sum below the input keeps the bit
	assign cmp_below_o = trial_code_i < ain_i;
	// buffer gated by busy, pulled up when released
	assign ext_clk_o = busy_n_i ? 1'b1 : osc_i;
endmodule

// ### sabi_ctrl_bench.sv
`timescale 1ns/1ns
module sabi_ctrl_bench;
	logic clk = 0, rst = 1, sel = 1, rd = 1, esel = 0, osc = 0, cmp, eclk, busy_n, run, oe_n;
	logic [7:0] ain = 8'h00, code, bus;
	int bad_count = 0, checks_done = 0, cyc = 0, mode, i, n, exp;
	bit rom = 0, ext = 0;
	sabi_ctrl #(.BIT_CYCLES(3), .ROM_CYCLES(2)) dut (.clock_i(clk), .reset_i(rst), .select_n_i(sel),
		.read_n_i(rd), .cmp_below_i(cmp), .ext_clk_sel_i(esel), .ext_clk_i(eclk), .busy_n_o(busy_n),
		.conv_clk_run_o(run), .trial_code_o(code), .result_bus_o(bus), .result_bus_oe_n_o(oe_n));
	sabi_far far (.ain_i(ain), .trial_code_i(code), .busy_n_i(busy_n), .osc_i(osc), .cmp_below_o(cmp),
		.ext_clk_o(eclk));
	initial begin
		forever #50 clk = ~clk;
	end
	always #200 osc = ~osc;
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			results();
		end
	end
	task chk(input logic [7:0] seen, input logic [7:0] want, input string what);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask
	task results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// read the result, release read; keep select low for a restart only in mode 2
	task fetch(input logic [7:0] want);
		sel <= 0;
		rd <= 0;
		for (i = 0; i < 10 && oe_n !== 0; i++) @(negedge clk);
		chk({7'h0, oe_n}, 8'h00, "oe_n");
		chk(bus, want, "result");
		rd <= 1;
		if (mode != 2) sel <= 1;
		repeat (6) @(negedge clk);
		chk({7'h0, oe_n}, 8'h01, "oe_n idle");
	endtask
	initial begin
		void'($urandom(32'h46993ecd));
		repeat (20) @(negedge clk);
		rst <= 0;
		repeat (2) @(negedge clk);
		mode = 0;
		fetch(8'h00);
		$display("dummy read done");
		for (n = 0; n < 12; n++) begin
			mode = $urandom % 3;
			if (!rom) begin
				ain = 8'h01 + $urandom % 255;
				ext = (mode != 2) && ($urandom % 2);
				esel <= ext;
				if (ext) @(posedge osc);
				if (mode == 0) begin
					sel <= 0;
					rd <= 0;
				end else begin
					sel <= 0;
					repeat (4) @(negedge clk);
					sel <= 1;
					@(negedge clk);
				end
			end
			for (i = 0; i < 20 && busy_n !== 0; i++) @(negedge clk);
			chk({7'h0, busy_n}, 8'h00, "busy low");
			if (mode != 0) begin
				sel <= 0;
				rd <= 0;
				repeat (3) @(negedge clk);
				chk({7'h0, oe_n}, 8'h01, "oe_n busy");
				rd <= 1;
				sel <= 1;
			end
			for (i = 0; i < 300 && busy_n !== 1; i++) @(negedge clk);
			chk({7'h0, busy_n}, 8'h01, "busy high");
			exp = 0;
			for (int b = 7; b >= 0; b--) if ((exp | (1 << b)) < ain) exp = exp | (1 << b);
			fetch(exp[7:0]);
			rom = mode == 2;
			$display("conversion %0d mode %0d done", n, mode);
		end
		sel <= 1;
		results();
	end
endmodule
